// >>> logic/lpm_pkg.sv
// constants and types shared by the light and proximity measure sequencer
package lpm_pkg;
  // operating_mode_field encodings
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_ALS_ONCE = 3'h1;
  localparam logic [2:0] MODE_IR_ONCE  = 3'h2;
  localparam logic [2:0] MODE_PRX_ONCE = 3'h3;
  localparam logic [2:0] MODE_RSVD     = 3'h4;
  localparam logic [2:0] MODE_ALS_CONT = 3'h5;
  localparam logic [2:0] MODE_IR_CONT  = 3'h6;
  localparam logic [2:0] MODE_PRX_CONT = 3'h7;
  // field positions inside the mode field
  localparam int MODE_CONT_BIT = 2;
  // persist_count_field targets
  localparam logic [4:0] PERSIST_0 = 5'h01;
  localparam logic [4:0] PERSIST_1 = 5'h04;
  localparam logic [4:0] PERSIST_2 = 5'h08;
  localparam logic [4:0] PERSIST_3 = 5'h10;
  // resolution selector to bit count
  localparam logic [4:0] RES_BITS_0 = 5'h10;
  localparam logic [4:0] RES_BITS_1 = 5'h0C;
  localparam logic [4:0] RES_BITS_2 = 5'h08;
  localparam logic [4:0] RES_BITS_3 = 5'h04;
  // reset values of the data and thresholds
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [15:0] LO_RESET   = 16'h0000;
  localparam logic [15:0] HI_RESET   = 16'hFFFF;
  // bus target address
  localparam logic [6:0] BUS_ADDR = 7'h44;
  // core clock rate and 360 kHz half period in core cycles
  localparam int CLK_HZ        = 40000000;
  localparam int MOD_HZ        = 360000;
  localparam int MOD_HALF      = CLK_HZ / (2 * MOD_HZ);
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INTEG = 2'b01,
    ST_DONE = 2'b10
  } lpm_state_type;
  // source selected by the mode
  typedef enum logic [1:0] {
    SRC_ALS = 2'b00,
    SRC_IR  = 2'b01,
    SRC_PRX = 2'b10
  } lpm_src_type;
endpackage

// >>> logic/lpm_ctrl.sv
// light and proximity measurement sequencer with link-side sampling
//
// Contract
// RULE_01: starts powered down, no conversion until commanded
// RULE_02: result data reads zero until first conversion
// RULE_03: single-shot mode starts one conversion of source
// RULE_04: single-shot returns to power-down, result kept
// RULE_05: continuous mode converts back to back, overwrites
// RULE_06: continuous stops only on power-down command; code also stops after a conversion if mode leaves continuous
// RULE_07: converter result is sixteen bits wide
// RULE_08: integration counter width four/eight/twelve/sixteen bits
// RULE_09: light and infrared results unsigned n bits
// RULE_10: result readable by host at any time
// RULE_11: four sensitivity ranges, one most sensitive
// RULE_12: proximity mode switches on led driver output
// RULE_13: led current and modulation follow config register
// RULE_14: six modes programmable in any order
// RULE_15: interrupt active low open drain, pull only
// RULE_16: interrupt condition also visible as status bit
// RULE_17: interrupt when result above high or below low
// RULE_18: consecutive out-of-window count is configurable
// RULE_19: three-bit mode field decode
// RULE_20: persistence field selects one, four, eight, sixteen
// RULE_21: interrupt held until first command transfer clears
// RULE_22: answers only fixed seven-bit target address
// RULE_23: persistence counter counts outside, restarts inside
module lpm_ctrl
  import lpm_pkg::*;
(
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // link clock: the converter oscillator domain
  input  wire logic        osc_clk,
  // command register one fields (from the serial bus slave)
  input  wire logic [2:0]  operating_mode_field,
  input  wire logic [1:0]  persist_count_field,
  input  wire logic        cmd1_write_done,
  // sensing_config_register fields
  input  wire logic        scheme_sel,
  input  wire logic        mod_freq_sel,
  input  wire logic [1:0]  led_current_sel,
  input  wire logic [1:0]  resolution_sel,
  input  wire logic [1:0]  range_sel,
  // interrupt thresholds
  input  wire logic [15:0] thresh_lo,
  input  wire logic [15:0] thresh_hi,
  // charge-balancing comparator pulse from the analog front end
  input  wire logic        balance_pulse,
  // analog front end controls
  output logic [1:0]       range_out,
  output logic [1:0]       source_sel,
  output logic             ir_led_drive_pin,
  output logic [1:0]       led_current_out,
  // results and status
  output logic [15:0]      result_data,
  output logic             int_flag,
  output logic             conv_busy,
  // open-drain interrupt pin, active low
  output logic             int_n_out,
  output logic             int_n_oe,
  // fixed bus address for the serial slave comparator
  output logic [6:0]       bus_target_addr
);
  import lpm_pkg::*;

  // core domain state
  typedef struct packed {
    lpm_state_type state;
    lpm_src_type   src;
    logic [2:0]    mode_seen;
    logic          start_tgl;
    logic [1:0]    done_sync;
    logic          done_last;
    logic [15:0]   data;
    logic [4:0]    persist;
    logic          flag;
    logic          led_on;
    logic [7:0]    mod_cnt;
    logic          mod_phase;
  } lpm_core_type;

  // oscillator domain state
  typedef struct packed {
    logic [1:0]    start_sync;
    logic          start_last;
    logic          run;
    logic [15:0]   osc_cnt;
    logic [15:0]   bal_cnt;
    logic [1:0]    bal_sync;
    logic          bal_last;
    logic [15:0]   word;
    logic          done_tgl;
  } lpm_osc_type;

  lpm_core_type core;      // registered core state
  lpm_core_type next_core; // next core state
  lpm_osc_type  osc;       // registered oscillator-side state
  lpm_osc_type  next_osc;  // next oscillator-side state

  logic [4:0]  res_bits;   // selected counter width
  logic [4:0]  persist_tgt;// selected persistence count
  logic [15:0] res_mask;   // mask of n low bits
  logic [15:0] osc_top;    // last oscillator count of an integration
  logic        done_evt;   // conversion finished, core domain

  // counter width and persistence target decode
  always_comb begin
    case (resolution_sel) // [RULE_08]
      2'h0:    res_bits = RES_BITS_0;
      2'h1:    res_bits = RES_BITS_1;
      2'h2:    res_bits = RES_BITS_2;
      default: res_bits = RES_BITS_3;
    endcase
    case (persist_count_field) // [RULE_20] [RULE_18]
      2'h0:    persist_tgt = PERSIST_0;
      2'h1:    persist_tgt = PERSIST_1;
      2'h2:    persist_tgt = PERSIST_2;
      default: persist_tgt = PERSIST_3;
    endcase
    // n-bit mask for the unsigned result
    res_mask = 16'((32'h1 << res_bits) - 32'h1); // [RULE_09]
    osc_top  = res_mask;
  end

  // oscillator domain: integrate balance pulses over 2^n osc ticks
  always_comb begin
    next_osc = osc;
    // start toggle crossing from core
    next_osc.start_sync = {osc.start_sync[0], core.start_tgl};
    next_osc.start_last = osc.start_sync[1];
    // balance pulse is an external pin: two flops first
    next_osc.bal_sync = {osc.bal_sync[0], balance_pulse};
    next_osc.bal_last = osc.bal_sync[1];
    if (osc.start_sync[1] != osc.start_last) begin
      // new integration begins
      next_osc.run     = 1'b1;
      next_osc.osc_cnt = 16'h0000;
      next_osc.bal_cnt = 16'h0000;
    end else if (osc.run) begin
      // count charge packets, saturating at sixteen bits
      if (osc.bal_sync[1] && !osc.bal_last &&
          osc.bal_cnt != 16'hFFFF) begin // [RULE_07]
        next_osc.bal_cnt = osc.bal_cnt + 16'h0001;
      end
      if (osc.osc_cnt == osc_top) begin
        // integration complete: publish word, toggle done
        next_osc.run      = 1'b0;
        next_osc.word     = osc.bal_cnt & res_mask; // [RULE_09]
        next_osc.done_tgl = ~osc.done_tgl;
      end else begin
        next_osc.osc_cnt = osc.osc_cnt + 16'h0001; // [RULE_08]
      end
    end
  end

  // oscillator domain register
  always_ff @(posedge osc_clk) begin
    if (sys_rst) begin
      osc <= '0;
    end else begin
      osc <= next_osc;
    end
  end

  // done edge seen after two-flop toggle synchroniser
  assign done_evt = core.done_sync[1] ^ core.done_last;

  // core sequencer, result capture and interrupt
  always_comb begin
    next_core = core;
    next_core.done_sync = {core.done_sync[0], osc.done_tgl};
    next_core.done_last = core.done_sync[1];
    next_core.mode_seen = operating_mode_field;
    case (core.state)
      ST_IDLE: begin
        // start on any newly written non-off, non-reserved mode
        if (operating_mode_field != MODE_OFF &&
            operating_mode_field != MODE_RSVD &&
            operating_mode_field != core.mode_seen) begin // [RULE_03]
          next_core.state     = ST_INTEG;
          next_core.start_tgl = ~core.start_tgl;
          // source follows the low two mode bits [RULE_19] [RULE_14]
          case (operating_mode_field[1:0])
            2'h1:    next_core.src = SRC_ALS;
            2'h2:    next_core.src = SRC_IR;
            default: next_core.src = SRC_PRX;
          endcase
        end
      end
      ST_INTEG: begin
        // led on while a proximity integration runs
        next_core.led_on = (core.src == SRC_PRX); // [RULE_12]
        if (operating_mode_field == MODE_OFF) begin
          // abandon the conversion on power-down
          next_core.state  = ST_IDLE; // [RULE_06]
          next_core.led_on = 1'b0;
        end else if (done_evt) begin
          next_core.data  = osc.word; // [RULE_05] [RULE_02]
          next_core.state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_core.led_on = 1'b0;
        if (operating_mode_field[MODE_CONT_BIT] &&
            operating_mode_field != MODE_RSVD) begin
          // continuous: restart at once
          next_core.state     = ST_INTEG; // [RULE_05]
          next_core.start_tgl = ~core.start_tgl;
        end else begin
          // single shot: power down, keep data [RULE_04]
          next_core.state = ST_IDLE;
        end
      end
      default: next_core.state = ST_IDLE;
    endcase
    // window check on each completed conversion
    if (core.state == ST_INTEG && done_evt &&
        operating_mode_field != MODE_OFF) begin
      if (osc.word > thresh_hi || osc.word < thresh_lo) begin // [RULE_17]
        if (core.persist != 5'h1F) begin
          next_core.persist = core.persist + 5'h01; // [RULE_23]
        end
      end else begin
        next_core.persist = 5'h00; // [RULE_23]
      end
    end
    // flag set wins over clear by command transfer
    if (cmd1_write_done) begin
      next_core.flag = 1'b0; // [RULE_21]
    end
    if (next_core.persist >= persist_tgt &&
        next_core.persist != core.persist) begin
      next_core.flag = 1'b1; // [RULE_18] [RULE_16]
    end
    // led modulation: dc or 360 kHz half-period toggling [RULE_13]
    if (core.mod_cnt == 8'(MOD_HALF - 1)) begin
      next_core.mod_cnt   = 8'h00;
      next_core.mod_phase = ~core.mod_phase;
    end else begin
      next_core.mod_cnt = core.mod_cnt + 8'h01;
    end
  end

  // core register; power-up is power-down with zero data [RULE_01]
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core       <= '0;
      core.state <= ST_IDLE;
      core.data  <= DATA_RESET; // [RULE_02]
    end else begin
      core <= next_core;
    end
  end

  // outputs
  assign result_data      = core.data; // [RULE_10]
  assign int_flag         = core.flag; // [RULE_16]
  // busy only while integrating: the one-cycle done state drops it, so
  // a continuous run shows a low pulse after every completed result
  assign conv_busy        = (core.state == ST_INTEG);
  assign range_out        = range_sel; // [RULE_11]
  assign source_sel       = core.src;
  assign led_current_out  = led_current_sel; // [RULE_13]
  assign ir_led_drive_pin = core.led_on &&
                            (!mod_freq_sel || core.mod_phase); // [RULE_13]
  assign int_n_out        = 1'b0; // [RULE_15]
  assign int_n_oe         = core.flag; // [RULE_15]
  assign bus_target_addr  = BUS_ADDR; // [RULE_22]

  // scheme select and thresholds reset values are held by the bus side
  logic unused_ok;
  assign unused_ok = scheme_sel;
endmodule

// >>> tb/lpm_ctrl_assertions.sv
// port assertions for the measure sequencer
module lpm_ctrl_checker
  import lpm_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // watched inputs
  input wire logic [2:0]  operating_mode_field,
  input wire logic        cmd1_write_done,
  input wire logic [1:0]  range_sel,
  input wire logic [1:0]  led_current_sel,
  // watched outputs
  input wire logic [1:0]  range_out,
  input wire logic [1:0]  led_current_out,
  input wire logic [1:0]  source_sel,
  input wire logic        ir_led_drive_pin,
  input wire logic [15:0] result_data,
  input wire logic        int_flag,
  input wire logic        conv_busy,
  input wire logic        int_n_out,
  input wire logic        int_n_oe,
  input wire logic [6:0]  bus_target_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_int_pull_only: assert property (int_n_out == 1'b0)
    else $error("interrupt pin driven high");
  a_int_pin_flag: assert property (int_n_oe == int_flag)
    else $error("interrupt pin and status differ");
  a_addr_fixed: assert property (bus_target_addr == BUS_ADDR)
    else $error("target address wrong");
  a_range_pass: assert property (
    range_sel == $past(range_sel) |-> range_out == range_sel)
    else $error("range not applied");
  a_led_current_pass: assert property (
    led_current_sel == $past(led_current_sel)
    |-> led_current_out == led_current_sel)
    else $error("led current not applied");
  a_reserved_ignored: assert property (
    operating_mode_field == MODE_RSVD && !conv_busy |=> !conv_busy)
    else $error("reserved mode started a conversion");
  a_off_stays_idle: assert property (
    operating_mode_field == MODE_OFF && !conv_busy |=> !conv_busy)
    else $error("conversion while powered down");
  a_flag_held: assert property (
    int_flag && !cmd1_write_done |=> int_flag)
    else $error("flag dropped without clear");
  a_flag_cleared: assert property (
    cmd1_write_done && int_flag && !conv_busy |=> !int_flag)
    else $error("flag not cleared");
  a_led_prox_only: assert property (
    ir_led_drive_pin |-> source_sel == 2'h2)
    else $error("led on outside proximity");
  a_idle_data_kept: assert property (
    !conv_busy ##1 !conv_busy |-> $stable(result_data))
    else $error("result changed while idle");
  a_cont_restart: assert property (
    operating_mode_field[2] && operating_mode_field != MODE_RSVD
    && $fell(conv_busy) ##1 $stable(operating_mode_field) |-> conv_busy)
    else $error("continuous mode did not restart");
endmodule

bind lpm_ctrl lpm_ctrl_checker i_lpm_ctrl_checker (
  .clk(clk), .sys_rst(sys_rst), .cmd1_write_done(cmd1_write_done),
  .operating_mode_field(operating_mode_field), .range_sel(range_sel),
  .led_current_sel(led_current_sel), .range_out(range_out),
  .led_current_out(led_current_out), .source_sel(source_sel),
  .ir_led_drive_pin(ir_led_drive_pin), .result_data(result_data),
  .int_flag(int_flag), .conv_busy(conv_busy), .int_n_out(int_n_out),
  .int_n_oe(int_n_oe), .bus_target_addr(bus_target_addr));

// >>> tb/lpm_front_model.sv
// comparator pulse model on the oscillator side
module lpm_front_model (
  // oscillator clock and reset
  input  wire logic       osc_clk,
  input  wire logic       sys_rst,
  // window and pulse spacing
  input  wire logic       active,
  input  wire logic [1:0] gap,
  // comparator pulse, pulled low outside windows
  output logic            balance_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt; // cycles since last toggle
  // toggles every gap+1 cycles, so counts stay below sixteen
  always @(posedge osc_clk) begin
    if (sys_rst || !active) begin
      cnt <= 2'h0;
      balance_pulse <= 1'b0;
    end else if (cnt >= gap) begin
      cnt <= 2'h0;
      balance_pulse <= !balance_pulse;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// >>> tb/test_lpm_ctrl.sv
// self-checking bench for the measure sequencer
module test_lpm_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import lpm_pkg::*;
  logic clk = 1'b0, osc_clk = 1'b0, sys_rst = 1'b1, cmd1_write_done = 1'b0;
  logic [2:0] operating_mode_field = 3'h0;
  logic [1:0] persist_count_field = 2'h0, gap = 2'h0;
  logic mod_freq_sel = 1'b0, balance_pulse, ir_led_drive_pin, int_flag;
  logic [1:0] led_current_sel = 2'h0, range_sel = 2'h0;
  logic [1:0] range_out, source_sel, led_current_out;
  logic [15:0] thresh_lo = 16'h0000, thresh_hi = 16'hFFFF, result_data;
  logic conv_busy, int_n_out, int_n_oe, int_n;
  logic [6:0] bus_target_addr;
  logic [31:0] seed = 32'h31E2; // random source state
  int comparisons = 0, miscompares = 0;
  // open-drain wire with pull-up
  assign int_n = int_n_oe ? int_n_out : 1'b1;
  always #12.5 clk = !clk;
  always #7.5 osc_clk = !osc_clk;
  lpm_ctrl i_lpm_ctrl (.clk(clk), .sys_rst(sys_rst), .osc_clk(osc_clk),
    .operating_mode_field(operating_mode_field), .scheme_sel(1'b0),
    .persist_count_field(persist_count_field), .range_sel(range_sel),
    .cmd1_write_done(cmd1_write_done), .mod_freq_sel(mod_freq_sel),
    .led_current_sel(led_current_sel), .resolution_sel(2'h3),
    .thresh_lo(thresh_lo), .thresh_hi(thresh_hi), .range_out(range_out),
    .balance_pulse(balance_pulse), .source_sel(source_sel),
    .ir_led_drive_pin(ir_led_drive_pin), .result_data(result_data),
    .led_current_out(led_current_out), .int_flag(int_flag),
    .conv_busy(conv_busy), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
    .bus_target_addr(bus_target_addr));
  lpm_front_model i_lpm_front_model (.osc_clk(osc_clk), .gap(gap),
    .sys_rst(sys_rst), .active(conv_busy), .balance_pulse(balance_pulse));
  // next random state
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one comparison
  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // prints counts and verdict, ends the run
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // bounded wait for a busy level
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy !== lvl && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) begin
      miscompares++;
      summarize();
    end
  endtask
  // one full conversion seen at the ports
  task automatic conv();
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask
  // one-cycle clear pulse after power-down
  task automatic clear_flag();
    operating_mode_field = MODE_OFF;
    wait_busy(1'b0);
    cmd1_write_done = 1'b1;
    @(negedge clk);
    cmd1_write_done = 1'b0;
    @(negedge clk);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("data", 16'h0, result_data);
    chk("busy", 0, conv_busy);
    chk("pin", 1, int_n);
    chk("addr", BUS_ADDR, bus_target_addr);
    $display("test reset done");
    for (int m = 1; m <= 3; m++) begin
      seed = lfsr(seed);
      gap = {1'b0, seed[0]};
      range_sel = seed[3:2];
      led_current_sel = seed[5:4];
      mod_freq_sel = (m == 3) ? 1'b0 : seed[6];
      operating_mode_field = m[2:0];
      repeat (2) @(negedge clk);
      chk("range", range_sel, range_out);
      chk("current", led_current_sel, led_current_out);
      chk("source", m - 1, source_sel);
      chk("led", m == 3, ir_led_drive_pin);
      wait_busy(1'b0);
      repeat (8) @(negedge clk);
      chk("auto off", 0, conv_busy);
      chk("width", 0, result_data[15:4]);
      chk("counts", 1, result_data != 0);
      operating_mode_field = MODE_OFF;
      @(negedge clk);
      $display("test single mode %0d done", m);
    end
    operating_mode_field = MODE_RSVD;
    repeat (20) @(negedge clk);
    chk("reserved", 0, conv_busy);
    thresh_hi = 16'h0000;
    persist_count_field = 2'h1;
    operating_mode_field = MODE_ALS_CONT;
    for (int k = 1; k <= 4; k++) begin
      conv();
      chk("persist", k == 4, int_flag);
    end
    chk("pin low", 0, int_n);
    operating_mode_field = MODE_OFF;
    wait_busy(1'b0);
    repeat (20) @(negedge clk);
    chk("stopped", 0, conv_busy);
    chk("held", 1, int_flag);
    clear_flag();
    chk("cleared", 0, int_flag);
    $display("test persistence done");
    thresh_hi = 16'hFFFF;
    persist_count_field = 2'h0;
    operating_mode_field = MODE_IR_CONT;
    repeat (3) conv();
    chk("inside", 0, int_flag);
    thresh_lo = 16'hFFF0;
    conv();
    chk("below low", 1, int_flag);
    clear_flag();
    operating_mode_field = MODE_PRX_CONT;
    conv();
    chk("prox run", 1, int_flag);
    clear_flag();
    $display("test window done");
    summarize();
  end
endmodule
